// *** design/mcg_top.sv ***
// Master clock generation: prescalers, loop model, CPU and system clocks, APB registers
//
// Notes on behaviour
// RQ1 - Master clock comes from oscillator via mechanism chosen in PLL config register.
// RQ2 - CPU clock equals master clock or half of it, per halve select bit.
// RQ3 - Core and external bus controller both run on the CPU clock.
// RQ4 - Peripheral system clock has the same frequency as the CPU clock.
// RQ5 - Bypass divides oscillator by (input divider + 1) times (output divider + 1).
// RQ6 - Bypass with both dividers zero makes master clock follow oscillator directly.
// RQ7 - Input divider reaches 3, output divider reaches 14; slowest bypass is /60.
// RQ8 - Mode 11 gives oscillator times (multiplier + 1) over both divider factors.
// RQ9 - While locking the loop changes master clock frequency gradually, never abruptly.
// RQ10 - In loop mode oscillator output passes output prescaler, dividing by (divider + 1).
// RQ11 - Band field picks oscillator range; code 11 is reserved. The loop model ignores the band; status only flags code 11.
// RQ12 - Halve select changes only at a master clock edge, no short CPU pulse.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mcg_top (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        oscIn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             mcClk,
   output logic             cpuClk,
   output logic             ebcClk,
   output logic             sysClk,
   output logic             pllLocked
);

   // Oscillator synchroniser
   logic oscS1_r;
   logic oscS2_r;
   logic oscS3_r;
   logic oscEdge;

   // Configuration registers
   logic [1:0]  mode_r;
   logic [1:0]  mode_nxt;
   logic [1:0]  idiv_r;
   logic [1:0]  idiv_nxt;
   logic [3:0]  odiv_r;
   logic [3:0]  odiv_nxt;
   logic [4:0]  mul_r;
   logic [4:0]  mul_nxt;
   logic [1:0]  band_r;
   logic [1:0]  band_nxt;
   logic        halveSw_r;
   logic        halveSw_nxt;

   // APB answer
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;

   // Prescaler and loop signals
   logic        refLvl;
   logic        refEdge;
   logic        refRise;
   logic        mcLvl;
   logic        mcEdge;
   logic        pllOn;
   logic        odivEdgeIn;
   logic        refEdgeIn;
   logic [15:0] perCnt_r;
   logic [15:0] perCnt_nxt;
   logic [15:0] period_r;
   logic [15:0] period_nxt;
   logic [15:0] thr_r;
   logic [15:0] thr_nxt;
   logic [16:0] acc_r;
   logic [16:0] acc_nxt;
   logic        vcoEdge_r;
   logic        vcoEdge_nxt;
   logic        locked_r;
   logic        locked_nxt;

   // Clock outputs
   logic        halveEff_r;
   logic        halveEff_nxt;
   logic        mcClk_r;
   logic        cpuClk_r;
   logic        cpuClk_nxt;
   logic        ebcClk_r;
   logic        sysClk_r;

   assign oscEdge    = oscS2_r ^ oscS3_r;
   assign pllOn      = (mode_r == mcg_pkg::MODE_PLL);                      // [RQ1] [RQ8]
   // A divide-by-one stage only takes an edge that moves it toward its input level,
   // so a phase left over from a wider divider cannot invert the copied duty cycle
   assign refEdgeIn  = oscEdge & ~((idiv_r == 2'h0) & (refLvl == oscS2_r));     // [RQ6]
   assign odivEdgeIn = pllOn ? vcoEdge_r
                             : (refEdge & ~((odiv_r == 4'h0) & (mcLvl == refLvl))); // [RQ10] [RQ5] [RQ6]
   assign refRise    = refEdge & refLvl;

   // Input prescaler, shared by both mechanisms
   mcg_div #(.W(mcg_pkg::DIV_W)) u_input_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .edgeIn  (refEdgeIn),
      .divVal  ({2'h0, idiv_r}),
      .clkOut  (refLvl),
      .edgeOut (refEdge)
   );                                                                      // [RQ5] [RQ6]

   // Output prescaler, fed by the reference or the loop oscillator
   mcg_div #(.W(mcg_pkg::DIV_W)) u_output_div (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .edgeIn  (odivEdgeIn),
      .divVal  (odiv_r),
      .clkOut  (mcLvl),
      .edgeOut (mcEdge)
   );                                                                      // [RQ5] [RQ10]

   // APB slave and configuration fields
   always_comb begin
      mode_nxt    = mode_r;
      idiv_nxt    = idiv_r;
      odiv_nxt    = odiv_r;
      mul_nxt     = mul_r;
      band_nxt    = band_r;
      halveSw_nxt = halveSw_r;
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      pready_nxt  = psel & penable & ~pready_r;
      if (psel && penable && !pready_r) begin
         prdata_nxt  = '0;
         pslverr_nxt = 1'b0;
         case (paddr)
            mcg_pkg::OFF_PLL_CONFIG: begin
               prdata_nxt[mcg_pkg::MODE_LSB +: mcg_pkg::MODE_W] = mode_r;
               prdata_nxt[mcg_pkg::IDIV_LSB +: mcg_pkg::IDIV_W] = idiv_r;
               prdata_nxt[mcg_pkg::ODIV_LSB +: mcg_pkg::ODIV_W] = odiv_r;
               prdata_nxt[mcg_pkg::MUL_LSB  +: mcg_pkg::MUL_W]  = mul_r;
               prdata_nxt[mcg_pkg::BAND_LSB +: mcg_pkg::BAND_W] = band_r;
            end
            mcg_pkg::OFF_SYS_CTRL2: begin
               prdata_nxt[mcg_pkg::CPU_HALVE_BIT] = halveSw_r;
            end
            mcg_pkg::OFF_STATUS: begin
               prdata_nxt[mcg_pkg::ST_PLL_ON_BIT]   = pllOn;
               prdata_nxt[mcg_pkg::ST_HALVE_BIT]    = halveEff_r;
               prdata_nxt[mcg_pkg::ST_BAND_RSV_BIT] = (band_r == mcg_pkg::BAND_RESERVED); // [RQ11]
               prdata_nxt[mcg_pkg::ST_LOCKED_BIT]   = locked_r;
            end
            default: begin
               pslverr_nxt = 1'b1;
            end
         endcase
      end
      // Writes land on the completing edge, when pready is seen high
      if (psel && penable && pready_r && pwrite) begin
         case (paddr)
            mcg_pkg::OFF_PLL_CONFIG: begin
               mode_nxt = pwdata[mcg_pkg::MODE_LSB +: mcg_pkg::MODE_W];    // [RQ1]
               idiv_nxt = pwdata[mcg_pkg::IDIV_LSB +: mcg_pkg::IDIV_W];    // [RQ7]
               odiv_nxt = pwdata[mcg_pkg::ODIV_LSB +: mcg_pkg::ODIV_W];
               if (odiv_nxt > mcg_pkg::ODIV_MAX) begin
                  odiv_nxt = mcg_pkg::ODIV_MAX;                            // [RQ7]
               end
               mul_nxt  = pwdata[mcg_pkg::MUL_LSB  +: mcg_pkg::MUL_W];
               band_nxt = pwdata[mcg_pkg::BAND_LSB +: mcg_pkg::BAND_W];    // [RQ11]
            end
            mcg_pkg::OFF_SYS_CTRL2: begin
               halveSw_nxt = pwdata[mcg_pkg::CPU_HALVE_BIT];               // [RQ2]
            end
            default: begin
               halveSw_nxt = halveSw_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_r    <= mcg_pkg::MODE_RST;
         idiv_r    <= mcg_pkg::IDIV_RST;
         odiv_r    <= mcg_pkg::ODIV_RST;
         mul_r     <= mcg_pkg::MUL_RST;
         band_r    <= mcg_pkg::BAND_RST;
         halveSw_r <= mcg_pkg::HALVE_RST;
         prdata_r  <= '0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         mode_r    <= mode_nxt;
         idiv_r    <= idiv_nxt;
         odiv_r    <= odiv_nxt;
         mul_r     <= mul_nxt;
         band_r    <= band_nxt;
         halveSw_r <= halveSw_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Oscillator pin passes two flops before the edge detector
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oscS1_r <= 1'b0;
         oscS2_r <= 1'b0;
         oscS3_r <= 1'b0;
      end else begin
         oscS1_r <= oscIn;
         oscS2_r <= oscS1_r;
         oscS3_r <= oscS2_r;
      end
   end

   // Loop model: measures the reference period and emits oscillator edges
   // at (multiplier + 1) times the reference rate from a phase accumulator.
   // Limitation: the loop rate is capped at one edge per clk_sys cycle.
   always_comb begin
      logic [5:0]  mulP1;
      logic [16:0] sum;
      logic [16:0] thrExt;
      logic [15:0] diff;
      mulP1       = {1'b0, mul_r} + 6'h01;
      thrExt      = {1'b0, thr_r};
      sum         = acc_r + {10'h000, mulP1, 1'b0};
      diff        = '0;
      acc_nxt     = sum;
      vcoEdge_nxt = 1'b0;
      perCnt_nxt  = (perCnt_r == mcg_pkg::PER_MAX) ? perCnt_r : perCnt_r + 16'h0001;
      period_nxt  = period_r;
      thr_nxt     = thr_r;
      locked_nxt  = (thr_r == period_r);
      if (sum >= thrExt) begin
         vcoEdge_nxt = 1'b1;                                               // [RQ8]
         acc_nxt     = sum - thrExt;
         if (acc_nxt >= thrExt) begin
            acc_nxt = '0;
         end
      end
      if (refRise) begin
         perCnt_nxt = '0;
         period_nxt = (perCnt_r == mcg_pkg::PER_MAX) ? perCnt_r : perCnt_r + 16'h0001;
         // Threshold moves a fraction of the error per reference period
         if (thr_r < period_r) begin
            diff    = period_r - thr_r;
            thr_nxt = thr_r + (diff >> mcg_pkg::SLEW_SHIFT) + 16'h0001;    // [RQ9]
         end else if (thr_r > period_r) begin
            diff    = thr_r - period_r;
            thr_nxt = thr_r - (diff >> mcg_pkg::SLEW_SHIFT) - 16'h0001;    // [RQ9]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         perCnt_r  <= '0;
         period_r  <= mcg_pkg::THR_INIT;
         thr_r     <= mcg_pkg::THR_INIT;
         acc_r     <= '0;
         vcoEdge_r <= 1'b0;
         locked_r  <= 1'b0;
      end else begin
         perCnt_r  <= perCnt_nxt;
         period_r  <= period_nxt;
         thr_r     <= thr_nxt;
         acc_r     <= acc_nxt;
         vcoEdge_r <= vcoEdge_nxt;
         locked_r  <= locked_nxt;
      end
   end

   // CPU clock: follows or halves the master clock. The select is only taken
   // at a master rising edge with the CPU clock low, where both modes agree.
   always_comb begin
      halveEff_nxt = halveEff_r;
      cpuClk_nxt   = cpuClk_r;
      if (mcEdge) begin
         if (mcLvl) begin
            if (!cpuClk_r) begin
               halveEff_nxt = halveSw_r;                                   // [RQ12]
               cpuClk_nxt   = 1'b1;
            end else begin
               cpuClk_nxt   = ~halveEff_r;                                 // [RQ2]
            end
         end else begin
            cpuClk_nxt = halveEff_r ? cpuClk_r : 1'b0;                     // [RQ2]
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         halveEff_r <= mcg_pkg::HALVE_RST;
         mcClk_r    <= 1'b0;
         cpuClk_r   <= 1'b0;
         ebcClk_r   <= 1'b0;
         sysClk_r   <= 1'b0;
      end else begin
         halveEff_r <= halveEff_nxt;
         mcClk_r    <= mcLvl;                                              // [RQ1] [RQ6]
         cpuClk_r   <= cpuClk_nxt;
         ebcClk_r   <= cpuClk_nxt;                                         // [RQ3]
         sysClk_r   <= cpuClk_nxt;                                         // [RQ4]
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign mcClk     = mcClk_r;
   assign cpuClk    = cpuClk_r;
   assign ebcClk    = ebcClk_r;
   assign sysClk    = sysClk_r;
   assign pllLocked = locked_r;

endmodule : mcg_top
`default_nettype wire

// *** include/mcg_pkg.sv ***
// Constants for the master clock generation block
package mcg_pkg;

   // APB register map (byte addresses)
   localparam int          ADDR_W         = 12;
   localparam logic [11:0] OFF_PLL_CONFIG = 12'h000;
   localparam logic [11:0] OFF_SYS_CTRL2  = 12'h004;
   localparam logic [11:0] OFF_STATUS     = 12'h008;

   // Field layout of pll_config_register
   localparam int MODE_LSB = 0;
   localparam int MODE_W   = 2;
   localparam int IDIV_LSB = 2;
   localparam int IDIV_W   = 2;
   localparam int ODIV_LSB = 4;
   localparam int ODIV_W   = 4;
   localparam int MUL_LSB  = 8;
   localparam int MUL_W    = 5;
   localparam int BAND_LSB = 13;
   localparam int BAND_W   = 2;

   // Field layout of second_system_control_register
   localparam int CPU_HALVE_BIT = 0;

   // Field layout of the status register
   localparam int ST_PLL_ON_BIT   = 0;
   localparam int ST_HALVE_BIT    = 1;
   localparam int ST_BAND_RSV_BIT = 2;
   localparam int ST_LOCKED_BIT   = 3;

   // Encodings and limits
   localparam logic [1:0] MODE_PLL      = 2'h3;
   localparam logic [1:0] BAND_RESERVED = 2'h3;
   localparam logic [3:0] ODIV_MAX      = 4'he;

   // Reset values
   localparam logic [1:0] MODE_RST  = 2'h0;
   localparam logic [1:0] IDIV_RST  = 2'h0;
   localparam logic [3:0] ODIV_RST  = 4'h0;
   localparam logic [4:0] MUL_RST   = 5'h00;
   localparam logic [1:0] BAND_RST  = 2'h0;
   localparam logic       HALVE_RST = 1'b0;

   // Prescaler counter width
   localparam int DIV_W = 4;

   // Loop model: reference period counter, phase accumulator, slew
   localparam int          PER_W      = 16;
   localparam int          ACC_W      = 17;
   localparam logic [15:0] PER_MAX    = 16'hffff;
   localparam logic [15:0] THR_INIT   = 16'h0100;
   localparam int          SLEW_SHIFT = 2;

endpackage : mcg_pkg

// *** design/mcg_div.sv ***
// Edge-counting prescaler: toggles its output every (divVal + 1) input edges
`timescale 1ns/1ps
`default_nettype none
module mcg_div #(
   parameter int W = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic         edgeIn,
   input  wire logic [W-1:0] divVal,
   output logic              clkOut,
   output logic              edgeOut
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         lvl_r;
   logic         lvl_nxt;
   logic         edge_r;
   logic         edge_nxt;

   // Counting both edges makes divide-by-one an exact copy of the input
   always_comb begin
      cnt_nxt  = cnt_r;
      lvl_nxt  = lvl_r;
      edge_nxt = 1'b0;
      if (edgeIn) begin
         if (cnt_r >= divVal) begin
            cnt_nxt  = '0;
            lvl_nxt  = ~lvl_r;
            edge_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         lvl_r  <= 1'b0;
         edge_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         lvl_r  <= lvl_nxt;
         edge_r <= edge_nxt;
      end
   end

   assign clkOut  = lvl_r;
   assign edgeOut = edge_r;
endmodule : mcg_div
`default_nettype wire

// *** verif/mcg_checker.sv ***
// Concurrent checks on the ports of the master clock generation block
`timescale 1ns/1ps
`default_nettype none
module mcg_checker (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        oscIn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mcClk,
   input wire logic        cpuClk,
   input wire logic        ebcClk,
   input wire logic        sysClk,
   input wire logic        pllLocked
);
   logic [14:0] cfgR;
   logic        oscD;
   logic [7:0]  oscAge;
   logic [7:0]  cfgAge;
   logic        cfgWr;
   logic        loopOn;
   logic        bypZero;
   logic        quiet;
   // Shadow of the config word, taken at the completing APB edge
   assign cfgWr   = psel && penable && pready && pwrite && paddr == mcg_pkg::OFF_PLL_CONFIG;
   assign loopOn  = cfgR[1:0] == mcg_pkg::MODE_PLL;
   assign bypZero = !loopOn && cfgR[7:2] == 6'h00;
   // Prescaler phase is undefined right after a reconfiguration, so checks wait
   assign quiet   = cfgAge == 8'hff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfgR   <= 15'h0000;
         oscD   <= 1'b0;
         oscAge <= 8'h00;
         cfgAge <= 8'h00;
      end else begin
         oscD   <= oscIn;
         oscAge <= (oscIn != oscD) ? 8'h00 : oscAge + {7'h00, oscAge != 8'hff};
         cfgAge <= cfgWr ? 8'h00 : cfgAge + {7'h00, cfgAge != 8'hff};
         if (cfgWr) begin
            cfgR <= pwdata[14:0];
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_APB_WAIT: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("pready missing in second access cycle");
   AST_APB_PULSE: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or longer than one cycle");
   AST_APB_ERR: assert property (pready && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > mcg_pkg::OFF_STATUS) && (!pslverr || prdata == 32'h0))
      else $error("pslverr or prdata wrong for address");
   AST_CPU_ALIGN: assert property ($changed(cpuClk) |-> $changed(mcClk))
      else $error("cpuClk changed away from a master clock edge");
   AST_CPU_RISE: assert property ($rose(cpuClk) |-> $rose(mcClk))
      else $error("cpuClk rose without master clock rise");
   AST_EBC_COPY: assert property (ebcClk == cpuClk)
      else $error("ebcClk differs from cpuClk");
   AST_SYS_COPY: assert property (sysClk == cpuClk)
      else $error("sysClk differs from cpuClk");
   AST_OSC_FOLLOW: assert property (bypZero && quiet && $changed(oscIn) |-> ##[1:8] $changed(mcClk))
      else $error("master clock did not follow oscillator edge");
   AST_BYP_SYNC: assert property (!loopOn && quiet && $changed(mcClk) |-> oscAge < 8'h0a)
      else $error("bypass master clock moved without oscillator edge");
   cover property (cfgWr && loopOn);
   cover property (bypZero && quiet && $rose(mcClk));
   cover property ($rose(pllLocked));
   cover property (pready && pslverr);
endmodule : mcg_checker
bind mcg_top mcg_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .oscIn(oscIn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mcClk(mcClk), .cpuClk(cpuClk), .ebcClk(ebcClk),
   .sysClk(sysClk), .pllLocked(pllLocked));
`default_nettype wire

// *** verif/mcg_osc_model.sv ***
// External oscillator source feeding the clock input pin
`timescale 1ns/1ps
`default_nettype none
module mcg_osc_model #(
   parameter int HI_NS = 40,
   parameter int LO_NS = 80
) (
   input  wire logic run,
   output logic      oscOut
);
   // Uneven duty so a copied input is told apart from a divided one
   initial begin
      oscOut = 1'b0;
      #3;
      forever begin
         oscOut = run;
         #HI_NS;
         oscOut = 1'b0;
         #LO_NS;
      end
   end
endmodule : mcg_osc_model
`default_nettype wire

// *** verif/master_clock_generation_tb.sv ***
// Self-checking bench for the master clock generation block
`timescale 1ns/1ps
`default_nettype none
module master_clock_generation_tb;
   localparam int OSC_CYC = 12;
   logic        clk_sys, rst_n, psel, penable, pwrite, oscRun, oscIn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic        pready, pslverr, mcClk, cpuClk, ebcClk, sysClk, pllLocked, errBit;
   int          error_cnt, compares, cy, hi;

   mcg_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .oscIn(oscIn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mcClk(mcClk), .cpuClk(cpuClk), .ebcClk(ebcClk), .sysClk(sysClk),
      .pllLocked(pllLocked));
   mcg_osc_model #(.HI_NS(40), .LO_NS(80)) oscModel (.run(oscRun), .oscOut(oscIn));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // Sampling jitter of the asynchronous pin allows a small tolerance
   function automatic logic [31:0] near(input int seen, input int exp, input int tol);
      return (seen >= exp - tol && seen <= exp + tol) ? exp : seen;
   endfunction : near

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("apbTimeout", 0, 1);
         finish_test();
      end
      rdVal = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic period(input logic useCpu, input int n, output int c, output int h);
      logic prev, cur;
      int   k, t;
      k = -1;
      t = 0;
      c = 0;
      h = 0;
      prev = 1'b1;
      while (k < n) begin
         @(posedge clk_sys);
         cur = useCpu ? cpuClk : mcClk;
         if (cur === 1'b1 && prev === 1'b0) k++;
         if (k == 0 && cur === 1'b1) h++;
         if (k >= 0) c++;
         prev = cur;
         t++;
         if (t > 9000) begin
            check("clkTimeout", 0, 1);
            finish_test();
         end
      end
      c = c - 1;
   endtask : period

   task automatic t_reset;
      apb(1'b0, mcg_pkg::OFF_PLL_CONFIG, 32'h0);
      check("cfgReset", rdVal, 32'h0);
      apb(1'b0, mcg_pkg::OFF_SYS_CTRL2, 32'h0);
      check("ctrl2Reset", rdVal, 32'h0);
      apb(1'b1, 12'h010, 32'hffff_ffff);
      apb(1'b0, 12'h010, 32'h0);
      check("unmappedErr", {31'h0, errBit}, 32'h1);
      check("unmappedData", rdVal, 32'h0);
   endtask : t_reset

   task automatic t_bypass(input logic [31:0] wv, input int fac, input logic [31:0] rb);
      apb(1'b1, mcg_pkg::OFF_PLL_CONFIG, wv);
      apb(1'b0, mcg_pkg::OFF_PLL_CONFIG, 32'h0);
      check("cfgRead", rdVal, rb);
      period(1'b0, 1, cy, hi);
      period(1'b0, 2, cy, hi);
      check("bypPeriod", near(cy, 2 * fac * OSC_CYC, 2), 2 * fac * OSC_CYC);
      if (fac == 1) check("bypHigh", near(hi, 4, 1), 4);
   endtask : t_bypass

   task automatic t_halve;
      apb(1'b1, mcg_pkg::OFF_SYS_CTRL2, 32'h1);
      // The select only takes hold at a master rising edge, so read status afterwards
      period(1'b1, 2, cy, hi);
      apb(1'b0, mcg_pkg::OFF_STATUS, 32'h0);
      check("halveState", {31'h0, rdVal[1]}, 32'h1);
      check("cpuHalf", near(cy, 4 * OSC_CYC, 2), 4 * OSC_CYC);
      check("ebcCopy", {31'h0, ebcClk}, {31'h0, cpuClk});
      check("sysCopy", {31'h0, sysClk}, {31'h0, cpuClk});
      apb(1'b1, mcg_pkg::OFF_SYS_CTRL2, 32'h0);
      period(1'b1, 2, cy, hi);
      check("cpuFull", near(cy, 2 * OSC_CYC, 2), 2 * OSC_CYC);
   endtask : t_halve

   task automatic t_loop(input logic [31:0] wv, input int num, input int den);
      int n;
      apb(1'b1, mcg_pkg::OFF_PLL_CONFIG, wv);
      // Lock flag is stale until the new reference period has been measured twice
      repeat (16 * OSC_CYC) @(posedge clk_sys);
      n = 0;
      while (pllLocked !== 1'b1 && n < 6000) begin
         @(posedge clk_sys);
         n++;
      end
      check("locked", {31'h0, pllLocked}, 32'h1);
      if (n >= 6000) finish_test();
      apb(1'b0, mcg_pkg::OFF_STATUS, 32'h0);
      check("loopOn", {31'h0, rdVal[0]}, 32'h1);
      period(1'b0, 8, cy, hi);
      check("loopPeriod", near(cy, 8 * OSC_CYC * den / num, 2), 8 * OSC_CYC * den / num);
   endtask : t_loop

   task automatic t_band;
      for (int b = 0; b < 4; b++) begin
         apb(1'b1, mcg_pkg::OFF_PLL_CONFIG, 32'(b) << 13);
         apb(1'b0, mcg_pkg::OFF_STATUS, 32'h0);
         check("bandReserved", {31'h0, rdVal[2]}, {31'h0, b == 3});
      end
   endtask : t_band

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      oscRun = 1'b1;
      error_cnt = 0;
      compares = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_bypass(32'h0000_0000, 1, 32'h0000_0000);
      t_halve();
      t_bypass(32'h0000_0024, 6, 32'h0000_0024);
      t_bypass(32'h0000_0002, 1, 32'h0000_0002);
      t_bypass(32'h0000_00fc, 60, 32'h0000_00ec);
      t_loop(32'h0000_0303, 4, 1);
      t_loop(32'h0000_0313, 4, 2);
      t_loop(32'h0000_0507, 6, 2);
      t_band();
      finish_test();
   end
endmodule : master_clock_generation_tb
`default_nettype wire
